// file: dpsc_pkg.sv
// Constants for the converter control register slice: offsets, field positions and reset values.
// Assumes that the serial programming port carries a 15-bit address and 8-bit data.
package dpsc_pkg;

  // Serial port geometry.
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int INSTR_BITS = 16;
  localparam int FRAME_BITS = 24;

  // Register offsets.
  localparam logic [14:0] ADDR_COEF2_LO = 15'h017e;
  localparam logic [14:0] ADDR_COEF2_HI = 15'h017f;
  localparam logic [14:0] ADDR_COEF3_LO = 15'h0180;
  localparam logic [14:0] ADDR_COEF3_HI = 15'h0181;
  localparam logic [14:0] ADDR_COEF_APPLY = 15'h0182;
  localparam logic [14:0] ADDR_BAND_CAL = 15'h01b4;
  localparam logic [14:0] ADDR_SWEEP_VAR = 15'h01b5;
  localparam logic [14:0] ADDR_LEVEL_RST = 15'h01b6;
  localparam logic [14:0] ADDR_OSC_BIAS = 15'h01bb;
  localparam logic [14:0] ADDR_VAR_REF = 15'h01c5;
  localparam logic [14:0] ADDR_SYNC_WIN = 15'h01fe;
  localparam logic [14:0] ADDR_RECEIVER_MASTER_POWERDOWN = 15'h0200;
  localparam logic [14:0] ADDR_LANE_PD = 15'h0201;
  localparam logic [14:0] ADDR_AUX_PD = 15'h0203;
  localparam logic [14:0] ADDR_RECOV_RST = 15'h0206;

  // Coefficient layout: staged coefficients are two, each 9 bits.
  localparam int COEF_W = 9;
  localparam int NUM_COEF = 2;
  localparam logic [8:0] RST_COEF = 9'h000;
  localparam int APPLY_BIT = 0;
  localparam logic RST_APPLY = 1'b0;

  // Band calibration register fields.
  localparam int LDB_BIT = 7;
  localparam int CAL_OFS_LSB = 3;
  localparam int BAND_SEL_BIT = 1;
  localparam int BAND_MSB_BIT = 0;
  localparam logic RST_LDB = 1'b0;
  localparam logic [3:0] RST_CAL_OFS = 4'hf;
  localparam logic RST_BAND_SEL = 1'b0;
  localparam logic RST_BAND_MSB = 1'b0;
  localparam logic [7:0] RSV_BAND_CAL = 8'h00;

  // Sweep and varactor register fields.
  localparam int SWEEP_LSB = 4;
  localparam int VAR_LSB = 0;
  localparam logic [3:0] RST_SWEEP = 4'h8;
  localparam logic [3:0] RST_VAR = 4'h3;

  // Oscillator level and reset register fields.
  localparam int OSC_RST_BIT = 6;
  localparam int UNUSED_SEL_LSB = 4;
  localparam int AMP_LSB = 0;
  localparam logic RST_OSC_RST_N = 1'b1;
  localparam logic [1:0] RST_UNUSED_SEL = 2'h0;
  localparam logic [3:0] RST_AMP = 4'ha;
  localparam logic [7:0] RSV_LEVEL_RST = 8'h00;

  // Oscillator bias register fields.
  localparam int TCF_LSB = 3;
  localparam int BIAS_LSB = 0;
  localparam logic [1:0] RST_TCF = 2'h0;
  localparam logic [2:0] RST_BIAS = 3'h1;
  localparam logic [7:0] RSV_OSC_BIAS = 8'h00;

  // Varactor reference register fields.
  localparam int VREF_LSB = 0;
  localparam logic [3:0] RST_VREF = 4'h8;
  localparam logic [7:0] RSV_VAR_REF = 8'h40;

  // Sync window, power-down and recovery reset fields.
  localparam logic [2:0] RST_SYNC_TOL = 3'h0;
  localparam logic RST_MASTER_OFF = 1'b1;
  localparam int NUM_LANES = 4;
  localparam logic [3:0] RST_LANE_MASK = 4'h0;
  localparam int SYNC_BUF_BIT = 1;
  localparam logic RST_SYNC_BUF = 1'b0;
  localparam logic RST_RECOV_N = 1'b1;

endpackage

// file: dpsc_reg_if.sv
// Register access bundle between the serial port engine and the register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface dpsc_reg_if;
  import dpsc_pkg::*;
  logic wr_stb; // One-cycle write pulse.
  logic [ADDR_W-1:0] addr; // Register address, captured after the instruction and held to the end of the frame.
  logic [DATA_W-1:0] wdata; // Write data, valid with wr_stb.
  logic [DATA_W-1:0] rdata; // Read data for addr, combinational.
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface // dpsc_reg_if

// file: dpsc_spi_slave.sv
// Serial programming port engine: 16-bit instruction (read flag and address) then one data byte.
// Assumes sclk, cs_n and sdi are synchronous to core_clk and sclk is far slower than core_clk.
`timescale 1ns/1ps
module dpsc_spi_slave import dpsc_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Serial pins.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // Register side.
  dpsc_reg_if.port rif
);

  logic sclk_q; // Previous sclk level for edge detection.
  logic [4:0] cnt_q; // Bits received in this frame.
  logic [15:0] shift_q; // Incoming bit shifter.
  logic rd_q; // Frame is a read.
  logic load_q; // Pulse: load read data into the transmit shifter.
  logic [7:0] tx_q; // Outgoing read data.
  logic rise; // Sclk rising edge.
  logic fall; // Sclk falling edge.

  assign rise = sclk & ~sclk_q & ~cs_n;
  assign fall = ~sclk & sclk_q & ~cs_n;

  // Edge detect register.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Receive shifter and bit counter; chip select high aborts any partial frame.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (cs_n) begin
      cnt_q <= 5'h00;
    end else if (rise && cnt_q < 5'(FRAME_BITS)) begin
      cnt_q <= cnt_q + 5'h01;
      shift_q <= {shift_q[14:0], sdi};
    end
  end

  // Instruction capture on the sixteenth rising edge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 1'b0;
      rif.addr <= '0;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (rise && cnt_q == 5'(INSTR_BITS - 1)) begin
        rd_q <= shift_q[14];
        rif.addr <= {shift_q[13:0], sdi};
        load_q <= shift_q[14];
      end
    end
  end

  // Write strobe on the last data bit of a write frame.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rif.wr_stb <= 1'b0;
      rif.wdata <= '0;
    end else begin
      rif.wr_stb <= rise && cnt_q == 5'(FRAME_BITS - 1) && !rd_q;
      if (rise && cnt_q == 5'(FRAME_BITS - 1)) begin
        rif.wdata <= {shift_q[6:0], sdi};
      end
    end
  end

  // Read data shifts out MSB first; the first fall after the instruction keeps bit 7 in place.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 8'h00;
    end else if (load_q) begin
      tx_q <= rif.rdata;
    end else if (fall && cnt_q > 5'(INSTR_BITS)) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign sdo = tx_q[7];
  // Drive only during the data phase of a read, so the pin is free otherwise.
  assign sdo_oe_n = ~(rd_q && !cs_n && cnt_q >= 5'(INSTR_BITS));

endmodule // dpsc_spi_slave

// file: dpsc_coef_stage.sv
// Staged-to-active copy of the programmable filter coefficients.
// Assumes apply is a register level that software raises after writing all staged values.
`timescale 1ns/1ps
module dpsc_coef_stage import dpsc_pkg::*; #(
  parameter int N = NUM_COEF,
  parameter int W = COEF_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Staged values and apply control.
  input wire logic [W-1:0] staged [N],
  input wire logic apply,
  // Values the filter uses.
  output logic [W-1:0] active [N]
);

  logic apply_q; // Previous apply level.
  logic take; // Rising edge of apply.

  // The filter sees a consistent set: a half-written coefficient never leaks through.
  assign take = apply & ~apply_q;

  // Apply edge detector.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apply_q <= 1'b0;
    end else begin
      apply_q <= apply;
    end
  end

  // One copy register per coefficient.
  for (genvar i = 0; i < N; i++) begin : g_coef
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        active[i] <= W'(RST_COEF);
      end else if (take) begin
        active[i] <= staged[i];
      end
    end
  end

endmodule // dpsc_coef_stage

// file: dpsc_regs.sv
// Control register bank for filter coefficients, converter clock PLL and serial receiver power.
// Assumes the serial programming port pins are synchronous to core_clk; the filter, PLL and
// receiver that consume these controls live outside.
//
// What this block does
// R1 - Coefficients are 9 bits: low byte, high bit0
// R2 - Apply bit at bit0 updates coefficients, resets 0
// R3 - Band select bit: clear auto, set forced band
// R4 - Forced band MSB is write-only bit0
// R5 - Calibration start offset bits 6:3, reset ones
// R6 - Load delay bypass bit7, reset zero
// R7 - Level sweep initial bits 7:4, reset eight
// R8 - Varactor gain bits 3:0, reset three
// R9 - Oscillator logic reset bit6, reset one
// R10 - Unused select bits 5:4 stored, no effect
// R11 - Oscillator amplitude bits 3:0, reset ten
// R12 - Sync tolerance 3 bits, upper bits read-only
// R13 - Master receiver power-down, resets to one
// R14 - Per-lane power-down mask, resets to zero
// R15 - Aux bit1 powers down sync output buffer
// R16 - Active-low recovery reset, resets to one
// R17 - Reset restores defaults; reserved bits keep defaults
`timescale 1ns/1ps
module dpsc_regs import dpsc_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Serial programming port.
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  // Programmable filter.
  output logic [COEF_W-1:0] filter_coef_two,
  output logic [COEF_W-1:0] filter_coef_three,
  // Converter clock PLL.
  output logic load_delay_bypass,
  output logic [3:0] osc_cal_start_offset,
  output logic forced_band_select,
  output logic forced_band_msb,
  output logic [3:0] level_sweep_initial,
  output logic [3:0] osc_varactor_gain,
  output logic osc_logic_reset_n,
  output logic [3:0] osc_amplitude,
  output logic [1:0] osc_bias_tempco,
  output logic [2:0] osc_bias_level,
  output logic [3:0] osc_varactor_ref,
  // Sync alignment.
  output logic [2:0] sync_tolerance,
  // Serial receiver power and reset.
  output logic receiver_master_off,
  output logic [NUM_LANES-1:0] lane_off_mask,
  output logic [NUM_LANES-1:0] lane_phy_off,
  output logic sync_buffer_off,
  output logic recovery_reset_n
);

  dpsc_reg_if rif (); // Port-to-bank access bundle.

  logic [COEF_W-1:0] coef_q [NUM_COEF]; // Staged coefficients.
  logic [COEF_W-1:0] coef_act [NUM_COEF]; // Coefficients in use by the filter.
  logic apply_q; // Coefficient apply control.
  logic ldb_q; // Load delay bypass.
  logic [3:0] cal_ofs_q; // Calibration start offset.
  logic band_sel_q; // Forced band select.
  logic band_msb_q; // Forced band MSB, write-only.
  logic [3:0] sweep_q; // Level sweep initial value.
  logic [3:0] var_q; // Varactor gain.
  logic osc_rst_n_q; // Oscillator logic reset, active low.
  logic [1:0] unused_sel_q; // Stored select with no effect.
  logic [3:0] amp_q; // Oscillator amplitude.
  logic [1:0] tcf_q; // Bias temperature coefficient.
  logic [2:0] bias_q; // Bias level.
  logic [3:0] vref_q; // Varactor reference.
  logic [2:0] sync_tol_q; // Sync tolerance in converter_clock cycles.
  logic master_off_q; // Whole receiver powered down.
  logic [NUM_LANES-1:0] lane_mask_q; // Per-lane power-down.
  logic sync_buf_q; // Sync output buffer powered down.
  logic recov_n_q; // Recovery logic reset, active low.

  // Serial port engine.
  dpsc_spi_slave u_spi (
    .core_clk (core_clk),
    .rstn (rstn),
    .sclk (spi_sclk),
    .cs_n (spi_cs_n),
    .sdi (spi_sdi),
    .sdo (spi_sdo),
    .sdo_oe_n (spi_sdo_oe_n),
    .rif (rif.port)
  );

  // Writes to one register; the address stays stable while the strobe is high.
  function automatic logic wr_to(input logic [14:0] a);
    return rif.wr_stb && rif.addr == a;
  endfunction

  // Staged coefficients; the filter only sees them after an apply edge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_COEF; i++) begin
        coef_q[i] <= RST_COEF; // [R17]
      end
    end else begin
      for (int i = 0; i < NUM_COEF; i++) begin
        if (wr_to(ADDR_COEF2_LO + 15'(2 * i))) begin
          coef_q[i][7:0] <= rif.wdata; // [R1]
        end
        if (wr_to(ADDR_COEF2_HI + 15'(2 * i))) begin
          coef_q[i][8] <= rif.wdata[0]; // [R1]
        end
      end
    end
  end

  // Apply control; its rising edge moves staged values to the filter.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apply_q <= RST_APPLY; // [R2]
    end else if (wr_to(ADDR_COEF_APPLY)) begin
      apply_q <= rif.wdata[APPLY_BIT]; // [R2]
    end
  end

  // Copy stage that keeps the filter on a complete coefficient set.
  dpsc_coef_stage u_coef (
    .core_clk (core_clk),
    .rstn (rstn),
    .staged (coef_q),
    .apply (apply_q),
    .active (coef_act)
  );

  assign filter_coef_two = coef_act[0]; // [R2]
  assign filter_coef_three = coef_act[1];

  // Band calibration control.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ldb_q <= RST_LDB; // [R6]
      cal_ofs_q <= RST_CAL_OFS; // [R5]
      band_sel_q <= RST_BAND_SEL;
      band_msb_q <= RST_BAND_MSB;
    end else if (wr_to(ADDR_BAND_CAL)) begin
      ldb_q <= rif.wdata[LDB_BIT]; // [R6]
      cal_ofs_q <= rif.wdata[CAL_OFS_LSB +: 4]; // [R5]
      band_sel_q <= rif.wdata[BAND_SEL_BIT]; // [R3]
      band_msb_q <= rif.wdata[BAND_MSB_BIT]; // [R4]
    end
  end

  // Sweep start and varactor gain.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sweep_q <= RST_SWEEP; // [R7]
      var_q <= RST_VAR; // [R8]
    end else if (wr_to(ADDR_SWEEP_VAR)) begin
      sweep_q <= rif.wdata[SWEEP_LSB +: 4]; // [R7]
      var_q <= rif.wdata[VAR_LSB +: 4]; // [R8]
    end
  end

  // Oscillator level and logic reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_rst_n_q <= RST_OSC_RST_N; // [R9]
      unused_sel_q <= RST_UNUSED_SEL;
      amp_q <= RST_AMP; // [R11]
    end else if (wr_to(ADDR_LEVEL_RST)) begin
      osc_rst_n_q <= rif.wdata[OSC_RST_BIT]; // [R9]
      unused_sel_q <= rif.wdata[UNUSED_SEL_LSB +: 2]; // [R10]
      amp_q <= rif.wdata[AMP_LSB +: 4]; // [R11]
    end
  end

  // Oscillator bias and varactor reference.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tcf_q <= RST_TCF;
      bias_q <= RST_BIAS;
      vref_q <= RST_VREF;
    end else begin
      if (wr_to(ADDR_OSC_BIAS)) begin
        tcf_q <= rif.wdata[TCF_LSB +: 2];
        bias_q <= rif.wdata[BIAS_LSB +: 3];
      end
      if (wr_to(ADDR_VAR_REF)) begin
        vref_q <= rif.wdata[VREF_LSB +: 4];
      end
    end
  end

  // Sync window; only the low three bits are writable.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_tol_q <= RST_SYNC_TOL; // [R12]
    end else if (wr_to(ADDR_SYNC_WIN)) begin
      sync_tol_q <= rif.wdata[2:0]; // [R12]
    end
  end

  // Receiver power-down and recovery reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      master_off_q <= RST_MASTER_OFF; // [R13]
      lane_mask_q <= RST_LANE_MASK; // [R14]
      sync_buf_q <= RST_SYNC_BUF;
      recov_n_q <= RST_RECOV_N; // [R16]
    end else begin
      if (wr_to(ADDR_RECEIVER_MASTER_POWERDOWN)) begin
        master_off_q <= rif.wdata[0]; // [R13]
      end
      if (wr_to(ADDR_LANE_PD)) begin
        lane_mask_q <= rif.wdata[NUM_LANES-1:0]; // [R14]
      end
      if (wr_to(ADDR_AUX_PD)) begin
        sync_buf_q <= rif.wdata[SYNC_BUF_BIT]; // [R15]
      end
      if (wr_to(ADDR_RECOV_RST)) begin
        recov_n_q <= rif.wdata[0]; // [R16]
      end
    end
  end

  // Read-back; reserved bits show their fixed defaults and unmapped addresses read zero.
  always_comb begin
    rif.rdata = 8'h00;
    case (rif.addr)
      ADDR_COEF2_LO: rif.rdata = coef_q[0][7:0]; // [R1]
      ADDR_COEF2_HI: rif.rdata = {7'h00, coef_q[0][8]};
      ADDR_COEF3_LO: rif.rdata = coef_q[1][7:0];
      ADDR_COEF3_HI: rif.rdata = {7'h00, coef_q[1][8]};
      ADDR_COEF_APPLY: rif.rdata = {7'h00, apply_q};
      // The forced band MSB cannot be read back and shows zero.
      ADDR_BAND_CAL: rif.rdata = RSV_BAND_CAL | {ldb_q, cal_ofs_q, 1'b0, band_sel_q, 1'b0}; // [R4] [R17]
      ADDR_SWEEP_VAR: rif.rdata = {sweep_q, var_q};
      ADDR_LEVEL_RST: rif.rdata = RSV_LEVEL_RST | {1'b0, osc_rst_n_q, unused_sel_q, amp_q}; // [R10]
      ADDR_OSC_BIAS: rif.rdata = RSV_OSC_BIAS | {3'h0, tcf_q, bias_q};
      ADDR_VAR_REF: rif.rdata = RSV_VAR_REF | {4'h0, vref_q}; // [R17]
      ADDR_SYNC_WIN: rif.rdata = {5'h00, sync_tol_q}; // [R12]
      ADDR_RECEIVER_MASTER_POWERDOWN: rif.rdata = {7'h00, master_off_q};
      ADDR_LANE_PD: rif.rdata = {4'h0, lane_mask_q};
      ADDR_AUX_PD: rif.rdata = {6'h00, sync_buf_q, 1'b0};
      ADDR_RECOV_RST: rif.rdata = {7'h00, recov_n_q};
      default: rif.rdata = 8'h00;
    endcase
  end

  // PLL and sync window controls. The unused select is kept only for read-back, since it steers nothing.
  assign load_delay_bypass = ldb_q; // [R6]
  assign osc_cal_start_offset = cal_ofs_q; // [R5]
  assign forced_band_select = band_sel_q; // [R3]
  assign forced_band_msb = band_msb_q; // [R4]
  assign level_sweep_initial = sweep_q; // [R7]
  assign osc_varactor_gain = var_q; // [R8]
  assign osc_logic_reset_n = osc_rst_n_q; // [R9]
  assign osc_amplitude = amp_q; // [R11]
  assign osc_bias_tempco = tcf_q;
  assign osc_bias_level = bias_q;
  assign osc_varactor_ref = vref_q;
  assign sync_tolerance = sync_tol_q; // [R12]

  // Receiver controls.
  assign receiver_master_off = master_off_q; // [R13]
  assign lane_off_mask = lane_mask_q; // [R14]
  assign sync_buffer_off = sync_buf_q; // [R15]
  assign recovery_reset_n = recov_n_q; // [R16]

  // Each lane is off if the master bit or its own mask bit says so.
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    assign lane_phy_off[l] = master_off_q | lane_mask_q[l]; // [R13] [R14]
  end

endmodule // dpsc_regs

// file: dpsc_regs_sva.sv
// Checker for the control register slice: output timing against serial frames and reset values.
// Assumes it is bound onto dpsc_regs, one core clock domain, asynchronous active-low reset.
`timescale 1ns/1ps
module dpsc_regs_chk import dpsc_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Serial port.
  input wire logic spi_cs_n,
  // Watched outputs.
  input wire logic [COEF_W-1:0] filter_coef_two,
  input wire logic [COEF_W-1:0] filter_coef_three,
  input wire logic forced_band_select,
  input wire logic [3:0] osc_cal_start_offset,
  input wire logic [3:0] level_sweep_initial,
  input wire logic [3:0] osc_varactor_gain,
  input wire logic osc_logic_reset_n,
  input wire logic [3:0] osc_amplitude,
  input wire logic [2:0] sync_tolerance,
  input wire logic receiver_master_off,
  input wire logic [NUM_LANES-1:0] lane_off_mask,
  input wire logic [NUM_LANES-1:0] lane_phy_off,
  input wire logic sync_buffer_off,
  input wire logic recovery_reset_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Select idle long enough that a write from the last frame has landed.
  sequence s_idle;
    spi_cs_n [*4];
  endsequence

  // First edge after reset release.
  sequence s_out_of_reset;
    $rose(rstn);
  endsequence

  AST_STABLE_IDLE: assert property (s_idle |-> $stable(filter_coef_two) && $stable(sync_tolerance) &&
    $stable(receiver_master_off) && $stable(lane_off_mask)) else $error("output moved with select idle");
  AST_COEF_LAG: assert property ($changed(filter_coef_two) || $changed(filter_coef_three) |->
    !$past(spi_cs_n, 3)) else $error("coefficient changed outside apply timing");
  AST_TOL_LAG: assert property ($changed(sync_tolerance) |-> !$past(spi_cs_n, 2))
    else $error("sync tolerance changed outside write timing");
  AST_BAND_LAG: assert property ($changed(forced_band_select) |-> !$past(spi_cs_n, 2))
    else $error("band select changed outside write timing");
  AST_LANE_OR: assert property (lane_phy_off == (lane_off_mask | {NUM_LANES{receiver_master_off}}))
    else $error("lane power-down not master or mask");
  AST_RST_PLL: assert property (s_out_of_reset |-> osc_cal_start_offset == 4'hf &&
    level_sweep_initial == 4'h8 && osc_varactor_gain == 4'h3) else $error("pll fields wrong after reset");
  AST_RST_OSC: assert property (s_out_of_reset |-> osc_logic_reset_n && osc_amplitude == 4'ha)
    else $error("oscillator fields wrong after reset");
  AST_RST_RX: assert property (s_out_of_reset |-> receiver_master_off && lane_off_mask == 4'h0 &&
    !sync_buffer_off && recovery_reset_n && sync_tolerance == 3'h0) else $error("receiver wrong after reset");
endmodule // dpsc_regs_chk

bind dpsc_regs dpsc_regs_chk u_dpsc_regs_chk (.core_clk(core_clk), .rstn(rstn), .spi_cs_n(spi_cs_n),
  .filter_coef_two(filter_coef_two), .filter_coef_three(filter_coef_three),
  .forced_band_select(forced_band_select), .osc_cal_start_offset(osc_cal_start_offset),
  .level_sweep_initial(level_sweep_initial), .osc_varactor_gain(osc_varactor_gain),
  .osc_logic_reset_n(osc_logic_reset_n), .osc_amplitude(osc_amplitude), .sync_tolerance(sync_tolerance),
  .receiver_master_off(receiver_master_off), .lane_off_mask(lane_off_mask), .lane_phy_off(lane_phy_off),
  .sync_buffer_off(sync_buffer_off), .recovery_reset_n(recovery_reset_n));

// file: tb_dpsc_regs.sv
// Self-checking testbench for the control register slice, driven through the serial port.
// Assumes a 200 MHz core clock; the serial clock runs at eight core cycles per bit.
`timescale 1ns/1ps
module tb;
  import dpsc_pkg::*;
  // Stimulus and observed outputs.
  logic core_clk = 1'b0, rstn = 1'b0, spi_sclk = 1'b0, spi_cs_n = 1'b1, spi_sdi = 1'b0;
  logic spi_sdo, spi_sdo_oe_n, load_delay_bypass, forced_band_select, forced_band_msb, osc_logic_reset_n;
  logic receiver_master_off, sync_buffer_off, recovery_reset_n;
  logic [COEF_W-1:0] filter_coef_two, filter_coef_three;
  logic [3:0] osc_cal_start_offset, level_sweep_initial, osc_varactor_gain, osc_amplitude, osc_varactor_ref;
  logic [3:0] lane_off_mask, lane_phy_off;
  logic [1:0] osc_bias_tempco;
  logic [2:0] osc_bias_level, sync_tolerance;
  int err_count = 0;
  int compares = 0;
  // Register map with read-back after reset, after writing ff and after writing 00.
  localparam logic [14:0] ADDRS [15] = '{ADDR_COEF2_LO, ADDR_COEF2_HI, ADDR_COEF3_LO, ADDR_COEF3_HI,
    ADDR_COEF_APPLY, ADDR_BAND_CAL, ADDR_SWEEP_VAR, ADDR_LEVEL_RST, ADDR_OSC_BIAS, ADDR_VAR_REF,
    ADDR_SYNC_WIN, ADDR_RECEIVER_MASTER_POWERDOWN, ADDR_LANE_PD, ADDR_AUX_PD, ADDR_RECOV_RST};
  localparam logic [7:0] RST_RD [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h78, 8'h83, 8'h4a, 8'h01,
    8'h48, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
  localparam logic [7:0] ONES_RD [15] = '{8'hff, 8'h01, 8'hff, 8'h01, 8'h01, 8'hfa, 8'hff, 8'h7f, 8'h1f,
    8'h4f, 8'h07, 8'h01, 8'h0f, 8'h02, 8'h01};
  localparam logic [7:0] ZERO_RD [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Every bench signal carries the name of the port it meets.
  dpsc_regs u_dpsc_regs (.*);

  // Free-running core clock, 5 ns period.
  always #2.5 core_clk = ~core_clk;

  // Waits n edges, then steps just past the edge so drives never race sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Compares one value; four-state equality so an unknown never matches.
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  // One frame, MSB first; nbits below 24 aborts the frame by raising select early.
  task automatic spi_frame(input logic rd, input logic [14:0] a, input logic [7:0] wd, input int nbits,
    output logic [7:0] rdv);
    logic [23:0] word;
    word = {rd, a, wd};
    rdv = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b0;
      spi_sdi = word[23-i];
      tick(4);
      if (i >= 16) begin
        rdv = {rdv[6:0], spi_sdo};
        if (rd) begin
          check("sdo_oe_n in data", 9'(spi_sdo_oe_n), 9'h000);
        end
      end
      spi_sclk = 1'b1;
      tick(4);
    end
    spi_sclk = 1'b0;
    tick(4);
    spi_cs_n = 1'b1;
    tick(4);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused;
    spi_frame(1'b0, a, d, 24, unused);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] want);
    logic [7:0] v;
    spi_frame(1'b1, a, 8'h00, 24, v);
    check($sformatf("reg %h", a), 9'(v), 9'(want));
    check("sdo_oe_n idle", 9'(spi_sdo_oe_n), 9'h001);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 15; i++) begin
      rd_chk(ADDRS[i], RST_RD[i]);
    end
    check("lane_phy_off", 9'(lane_phy_off), 9'h00f);
    check("lane_off_mask", 9'(lane_off_mask), 9'h000);
    check("cal_offset", 9'(osc_cal_start_offset), 9'h00f);
    check("bias_level", 9'(osc_bias_level), 9'h001);
    check("bias_tempco", 9'(osc_bias_tempco), 9'h000);
    check("varactor_ref", 9'(osc_varactor_ref), 9'h008);
    $display("test reset_values done");
  endtask

  task automatic t_fields;
    for (int i = 0; i < 15; i++) begin
      wr(ADDRS[i], 8'hff);
    end
    for (int i = 0; i < 15; i++) begin
      rd_chk(ADDRS[i], ONES_RD[i]);
    end
    check("coef_two", filter_coef_two, 9'h1ff);
    check("coef_three", filter_coef_three, 9'h1ff);
    check("forced_band_msb", 9'(forced_band_msb), 9'h001);
    check("forced_band_select", 9'(forced_band_select), 9'h001);
    check("load_delay_bypass", 9'(load_delay_bypass), 9'h001);
    check("level_sweep", 9'(level_sweep_initial), 9'h00f);
    check("osc_amplitude", 9'(osc_amplitude), 9'h00f);
    check("sync_tolerance", 9'(sync_tolerance), 9'h007);
    check("sync_buffer_off", 9'(sync_buffer_off), 9'h001);
    for (int i = 0; i < 15; i++) begin
      wr(ADDRS[i], 8'h00);
    end
    for (int i = 0; i < 15; i++) begin
      rd_chk(ADDRS[i], ZERO_RD[i]);
    end
    check("master_off", 9'(receiver_master_off), 9'h000);
    check("recovery_reset_n", 9'(recovery_reset_n), 9'h000);
    check("osc_logic_reset_n", 9'(osc_logic_reset_n), 9'h000);
    check("osc_varactor_gain", 9'(osc_varactor_gain), 9'h000);
    wr(ADDR_LANE_PD, 8'h05);
    check("lane_phy_off", 9'(lane_phy_off), 9'h005);
    wr(15'h01b7, 8'hff);
    rd_chk(15'h01b7, 8'h00);
    $display("test field_access done");
  endtask

  // Staged values must not reach the filter until the apply bit rises.
  task automatic t_coef;
    wr(ADDR_COEF2_LO, 8'h5a);
    wr(ADDR_COEF2_HI, 8'h03);
    wr(ADDR_COEF3_LO, 8'ha5);
    wr(ADDR_COEF3_HI, 8'h00);
    check("coef_two staged", filter_coef_two, 9'h1ff);
    rd_chk(ADDR_COEF2_HI, 8'h01);
    wr(ADDR_COEF_APPLY, 8'h01);
    check("coef_two", filter_coef_two, 9'h15a);
    check("coef_three", filter_coef_three, 9'h0a5);
    wr(ADDR_COEF2_LO, 8'h11);
    check("coef_two held", filter_coef_two, 9'h15a);
    wr(ADDR_COEF_APPLY, 8'h00);
    wr(ADDR_COEF_APPLY, 8'h01);
    check("coef_two reapplied", filter_coef_two, 9'h111);
    $display("test coef_apply done");
  endtask

  // A frame cut short must leave the register alone.
  task automatic t_abort;
    logic [7:0] unused;
    spi_frame(1'b0, ADDR_SYNC_WIN, 8'h06, 20, unused);
    check("sync_tolerance", 9'(sync_tolerance), 9'h000);
    rd_chk(ADDR_SYNC_WIN, 8'h00);
    $display("test frame_abort done");
  endtask

  task automatic t_mid_reset;
    wr(ADDR_RECOV_RST, 8'h00);
    wr(ADDR_BAND_CAL, 8'h02);
    check("forced_band_select", 9'(forced_band_select), 9'h001);
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(2);
    check("recovery_reset_n", 9'(recovery_reset_n), 9'h001);
    check("coef_two", filter_coef_two, 9'h000);
    rd_chk(ADDR_BAND_CAL, 8'h78);
    $display("test mid_reset done");
  endtask

  task automatic summarize;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    tick(2);
    t_reset();
    t_fields();
    t_coef();
    t_abort();
    t_mid_reset();
    summarize();
  end

  // About 100 frames of 200 cycles should take near 100 us; cut a hang at 400 us.
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule // tb
